// ==== rtl/srx_pkg.sv ====
// Purpose: shared constants for the serial receive unit
// Assumes: 32-bit AXI4-Lite register window, word aligned
// Notes: all offsets are byte addresses
package srx_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_MODE = 6'h04;
  localparam logic [5:0] OFF_BAUD = 6'h08;
  localparam logic [5:0] OFF_STATUS = 6'h0C;
  localparam logic [5:0] OFF_MASK = 6'h10;
  localparam logic [5:0] OFF_RXDATA = 6'h14;
  localparam logic [5:0] OFF_POWER = 6'h18;
  localparam logic [5:0] OFF_TXDATA = 6'h1C;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTRL_RE = 0;
  localparam int CTRL_TE = 1;
  localparam int CTRL_CKLO = 2;
  localparam int CTRL_CKHI = 3;
  localparam int CTRL_W = 4;
  localparam int MODE_SYNC = 0;
  localparam int MODE_PAR_EN = 1;
  localparam int MODE_PAR_ODD = 2;
  localparam int MODE_W = 3;
  localparam int ST_RXF = 0;
  localparam int ST_OVERRUN_ERROR_FLAG = 1;
  localparam int ST_FER = 2;
  localparam int ST_PER = 3;
  localparam int ST_W = 4;
  localparam int ST_TXE = 4;
  localparam int ST_TXSH_LO = 8;
  localparam int PWR_STOP = 0;
  localparam int PWR_STBY = 1;
  localparam int PWR_W = 2;

  // ------------------------------------------------------------
  // reset values and sizes
  // ------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int BAUD_W = 16;
  localparam logic [7:0] RXDATA_RST = 8'h00;
  localparam logic [15:0] BAUD_RST = 16'h000F;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] PH_MID = 4'(OVERSAMPLE / 2 - 1);
  localparam logic [2:0] LAST_BIT = 3'(DATA_W - 1);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PAR,
    RX_STOP
  } srx_state_t;

endpackage : srx_pkg

// ==== rtl/srx_baud.sv ====
// Purpose: internal baud-rate generator, one tick per divisor+1 clocks
// Assumes: ticks are sixteen times the bit rate
// Notes: held in reset while disabled so the first tick is a full period
`timescale 1ns/1ps
module srx_baud #(
  parameter int DIV_W = srx_pkg::BAUD_W
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic enable,
  input wire logic [DIV_W-1:0] divisor,
  output logic tick
);

  logic [DIV_W-1:0] count;
  wire atEnd = (count >= divisor);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count <= '0;
      tick <= 1'b0;
    end else if (ce) begin
      if (!enable) begin
        count <= '0;
        tick <= 1'b0;
      end else begin
        count <= atEnd ? '0 : count + 1'b1;
        tick <= atEnd;
      end
    end
  end

endmodule : srx_baud

// ==== rtl/srx_unit.sv ====
// Purpose: serial receive path with clock selection and enable handling
// Assumes: AXI4-Lite master keeps one write and one read in flight
// Notes: pins pass a three-stage synchroniser before use
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module srx_unit #(
  parameter int DIV_W = srx_pkg::BAUD_W
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxdPin,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe_n,
  output logic irq
);

  // ------------------------------------------------------------
  // software-visible state
  // ------------------------------------------------------------
  logic [srx_pkg::CTRL_W-1:0] serialControlReg;
  logic [srx_pkg::MODE_W-1:0] serialModeReg;
  logic [DIV_W-1:0] baudDiv;
  logic [srx_pkg::ST_W-1:0] status;
  logic [srx_pkg::ST_W-1:0] irqMask;
  logic [srx_pkg::PWR_W-1:0] power;
  logic [srx_pkg::DATA_W-1:0] rxDataBuffer;
  logic [srx_pkg::DATA_W-1:0] txData;
  logic [srx_pkg::DATA_W-1:0] txShiftReg;
  logic txBufferEmptyFlag;

  // ------------------------------------------------------------
  // AXI4-Lite write channel
  // ------------------------------------------------------------
  logic awHeld;
  logic wHeld;
  logic [5:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  wire awFire = s_axi_awvalid && s_axi_awready;
  wire wFire = s_axi_wvalid && s_axi_wready;
  wire wrDo = awHeld && wHeld;

  wire hitCtrl = (awAddr == srx_pkg::OFF_CTRL);
  wire hitMode = (awAddr == srx_pkg::OFF_MODE);
  wire hitBaud = (awAddr == srx_pkg::OFF_BAUD);
  wire hitStatus = (awAddr == srx_pkg::OFF_STATUS);
  wire hitMask = (awAddr == srx_pkg::OFF_MASK);
  wire hitRxData = (awAddr == srx_pkg::OFF_RXDATA);
  wire hitPower = (awAddr == srx_pkg::OFF_POWER);
  wire hitTxData = (awAddr == srx_pkg::OFF_TXDATA);
  // a write to the receive buffer is acknowledged but stores nothing
  wire wrMapped = hitCtrl || hitMode || hitBaud || hitStatus || hitMask
                  || hitRxData || hitPower || hitTxData;
  wire lane0 = wrDo && wStrb[0];
  wire lane1 = wrDo && wStrb[1];
  wire wrCtrl = lane0 && hitCtrl;
  wire wrMode = lane0 && hitMode;
  wire wrStatus = lane0 && hitStatus;
  wire wrMask = lane0 && hitMask;
  wire wrPower = lane0 && hitPower;
  wire wrTxData = lane0 && hitTxData;
  wire wrBaudLo = lane0 && hitBaud;
  wire wrBaudHi = lane1 && hitBaud;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= '0;
      wData <= '0;
      wStrb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= srx_pkg::RESP_OKAY;
    end else if (ce) begin
      if (awFire) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (wFire) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (wrDo) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? srx_pkg::RESP_OKAY : srx_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite read channel
  // ------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  wire arFire = s_axi_arvalid && s_axi_arready;
  // the receive shifter has no address, so software never sees it
  wire [31:0] statusWord = {16'h0000, txShiftReg, 3'b000,
                            txBufferEmptyFlag, status};
  wire rdCtrl = (s_axi_araddr == srx_pkg::OFF_CTRL);
  wire rdMode = (s_axi_araddr == srx_pkg::OFF_MODE);
  wire rdBaud = (s_axi_araddr == srx_pkg::OFF_BAUD);
  wire rdStatus = (s_axi_araddr == srx_pkg::OFF_STATUS);
  wire rdMask = (s_axi_araddr == srx_pkg::OFF_MASK);
  wire rdRxData = (s_axi_araddr == srx_pkg::OFF_RXDATA);
  wire rdPower = (s_axi_araddr == srx_pkg::OFF_POWER);
  wire rdTxData = (s_axi_araddr == srx_pkg::OFF_TXDATA);
  wire rdMapped = rdCtrl || rdMode || rdBaud || rdStatus || rdMask
                  || rdRxData || rdPower || rdTxData;
  wire [31:0] rdMux =
    rdCtrl ? 32'(serialControlReg) :
    rdMode ? 32'(serialModeReg) :
    rdBaud ? 32'(baudDiv) :
    rdStatus ? statusWord :
    rdMask ? 32'(irqMask) :
    rdRxData ? 32'(rxDataBuffer) :
    rdPower ? 32'(power) :
    rdTxData ? 32'(txData) : 32'h00000000;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= srx_pkg::RESP_OKAY;
    end else if (ce) begin
      if (arFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdMapped ? srx_pkg::RESP_OKAY : srx_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      serialControlReg <= '0;
      serialModeReg <= '0;
      baudDiv <= DIV_W'(srx_pkg::BAUD_RST);
      irqMask <= '0;
      power <= '0;
    end else if (ce) begin
      if (wrCtrl) serialControlReg <= wData[srx_pkg::CTRL_W-1:0];
      if (wrMode) serialModeReg <= wData[srx_pkg::MODE_W-1:0];
      if (wrMask) irqMask <= wData[srx_pkg::ST_W-1:0];
      if (wrPower) power <= wData[srx_pkg::PWR_W-1:0];
      if (wrBaudLo) baudDiv[7:0] <= wData[7:0];
      if (wrBaudHi) baudDiv[DIV_W-1:8] <= wData[DIV_W-1:8];
    end
  end

  wire rxEnable = serialControlReg[srx_pkg::CTRL_RE];
  wire txEnable = serialControlReg[srx_pkg::CTRL_TE];
  wire syncMode = serialModeReg[srx_pkg::MODE_SYNC];
  wire parityOn = serialModeReg[srx_pkg::MODE_PAR_EN] && !syncMode;
  wire parityOdd = serialModeReg[srx_pkg::MODE_PAR_ODD];
  wire asleep = power[srx_pkg::PWR_STOP] || power[srx_pkg::PWR_STBY];

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // bit 1 is the clock pin, bit 0 the data pin; idle level is high
  wire [1:0] pinRaw = {sckIn, rxdPin};
  logic [1:0] pinS1;
  logic [1:0] pinS2;
  logic [1:0] pinS3;
  logic [1:0] pinLvl;
  wire [1:0] pinAgree = ~(pinS2 ^ pinS3);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pinS1 <= 2'h3;
      pinS2 <= 2'h3;
      pinS3 <= 2'h3;
      pinLvl <= 2'h3;
    end else if (ce) begin
      pinS1 <= pinRaw;
      pinS2 <= pinS1;
      pinS3 <= pinS2;
      pinLvl <= (pinAgree & pinS2) | (~pinAgree & pinLvl);
    end
  end

  wire rxLvl = pinLvl[0];
  wire sckRise = pinAgree[1] && pinS2[1] && !pinLvl[1];

  // ------------------------------------------------------------
  // clock selection
  // ------------------------------------------------------------
  wire extClock = serialControlReg[srx_pkg::CTRL_CKHI];
  wire clkOutOn = !extClock && (syncMode || serialControlReg[srx_pkg::CTRL_CKLO]);
  logic baudTick;

  srx_baud #(
    .DIV_W(DIV_W)
  ) u_baud (
    .clock(clock),
    .sys_rst(sys_rst),
    .ce(ce),
    .enable(!extClock && !asleep),
    .divisor(baudDiv),
    .tick(baudTick)
  );

  // async external clock is taken as the sixteen-times sample clock
  wire tick16 = extClock ? (sckRise && !syncMode) : baudTick;
  logic [3:0] phase;
  srx_pkg::srx_state_t rxState;
  wire startSeen = !syncMode && rxEnable && !asleep && tick16
                   && (rxState == srx_pkg::RX_IDLE) && !rxLvl;

  // restarting the phase on the start edge puts sample and clock edge mid-bit
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      phase <= '0;
    end else if (ce) begin
      if (startSeen) phase <= '0;
      else if (tick16) phase <= phase + 1'b1;
    end
  end

  wire midTick = tick16 && (phase == srx_pkg::PH_MID);
  wire bitEdge = (syncMode && extClock) ? sckRise : midTick;

  // phase bit 3 rises as phase leaves its midpoint, once per bit time
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sckOut <= 1'b1;
      sckOe_n <= 1'b1;
    end else if (ce) begin
      sckOut <= clkOutOn ? phase[3] : 1'b1;
      sckOe_n <= !clkOutOn;
    end
  end

  // ------------------------------------------------------------
  // receive shifter and sequencer
  // ------------------------------------------------------------
  logic [srx_pkg::DATA_W-1:0] rxShiftReg;
  logic [2:0] bitCount;
  logic parityBit;
  logic xferReq;
  logic xferFramingErr;
  logic xferParityErr;
  wire lastBit = (bitCount == srx_pkg::LAST_BIT);
  wire parityBad = parityOn && ((^rxShiftReg ^ parityBit) != parityOdd);

  // dropping the enable only idles the sequencer; flags and buffer stay
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rxState <= srx_pkg::RX_IDLE;
      rxShiftReg <= '0;
      bitCount <= '0;
      parityBit <= 1'b0;
      xferReq <= 1'b0;
      xferFramingErr <= 1'b0;
      xferParityErr <= 1'b0;
    end else if (ce) begin
      xferReq <= 1'b0;
      if (!rxEnable || asleep) begin
        rxState <= srx_pkg::RX_IDLE;
        bitCount <= '0;
      end else begin
        case (rxState)
          srx_pkg::RX_IDLE: begin
            bitCount <= '0;
            if (syncMode) rxState <= srx_pkg::RX_DATA;
            else if (startSeen) rxState <= srx_pkg::RX_START;
          end
          srx_pkg::RX_START: begin
            if (bitEdge) rxState <= rxLvl ? srx_pkg::RX_IDLE : srx_pkg::RX_DATA;
          end
          srx_pkg::RX_DATA: begin
            if (bitEdge) begin
              rxShiftReg <= {rxLvl, rxShiftReg[srx_pkg::DATA_W-1:1]};
              bitCount <= bitCount + 1'b1;
              if (lastBit && syncMode) begin
                xferReq <= 1'b1;
                xferFramingErr <= 1'b0;
                xferParityErr <= 1'b0;
              end else if (lastBit) begin
                rxState <= parityOn ? srx_pkg::RX_PAR : srx_pkg::RX_STOP;
              end
            end
          end
          srx_pkg::RX_PAR: begin
            if (bitEdge) begin
              parityBit <= rxLvl;
              rxState <= srx_pkg::RX_STOP;
            end
          end
          srx_pkg::RX_STOP: begin
            if (bitEdge) begin
              xferReq <= 1'b1;
              xferFramingErr <= !rxLvl;
              xferParityErr <= parityBad;
              rxState <= srx_pkg::RX_IDLE;
            end
          end
          default: rxState <= srx_pkg::RX_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // receive buffer and status flags
  // ------------------------------------------------------------
  wire moveByte = xferReq && !status[srx_pkg::ST_RXF];
  wire overrun = xferReq && status[srx_pkg::ST_RXF];
  wire [srx_pkg::ST_W-1:0] setBits = {moveByte && xferParityErr,
                                      moveByte && xferFramingErr,
                                      overrun, moveByte};
  wire [srx_pkg::ST_W-1:0] clrBits = wrStatus ? wData[srx_pkg::ST_W-1:0] : '0;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rxDataBuffer <= srx_pkg::RXDATA_RST;
    end else if (ce) begin
      if (asleep) rxDataBuffer <= srx_pkg::RXDATA_RST;
      else if (moveByte) rxDataBuffer <= rxShiftReg;
    end
  end

  // a new event in the clearing cycle keeps its bit set
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status <= '0;
    end else if (ce) begin
      status <= (status & ~clrBits) | setBits;
    end
  end

  assign irq = |(status & irqMask);

  // ------------------------------------------------------------
  // transmit buffer handling
  // ------------------------------------------------------------
  // only the enable behaviour of the transmit side lives here
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      txData <= '0;
      txShiftReg <= '0;
      txBufferEmptyFlag <= 1'b1;
    end else if (ce) begin
      if (wrTxData) txData <= wData[srx_pkg::DATA_W-1:0];
      if (!txEnable) begin
        txBufferEmptyFlag <= 1'b1;
        txShiftReg <= '0;
      end else if (wrTxData) begin
        txBufferEmptyFlag <= 1'b0;
      end else if (!txBufferEmptyFlag) begin
        txShiftReg <= txData;
        txBufferEmptyFlag <= 1'b1;
      end
    end
  end

endmodule : srx_unit

// ==== sim/srx_partner.sv ====
// Purpose: far-side serial sender for the receive unit
// Assumes: TICK system clocks per sixteenth of a bit
// Notes: line idles high as if pulled up; clock pin runs free
`timescale 1ns/1ps
module srx_partner #(
  parameter int TICK = 8
) (
  input wire logic clock,
  input wire logic send,
  input wire logic [7:0] byteIn,
  input wire logic stopVal,
  output logic rxd,
  output logic sck,
  output logic busy
);
  int tickCnt;
  int bitCnt;
  int pos;
  logic [9:0] frame;

  initial begin
    rxd = 1'b1;
    sck = 1'b1;
    busy = 1'b0;
    tickCnt = 0;
    bitCnt = 0;
    pos = 0;
    frame = '1;
  end

  // never stopped, even while software reconfigures
  always @(posedge clock) begin
    tickCnt <= (tickCnt == TICK - 1) ? 0 : tickCnt + 1;
    sck <= (tickCnt < TICK / 2);
  end

  // start low, data lsb first, then stop; stopVal low makes a bad frame
  always @(posedge clock) begin
    if (!busy && send) begin
      frame <= {stopVal, byteIn, 1'b0};
      busy <= 1'b1;
      bitCnt <= 0;
      pos <= 0;
      rxd <= 1'b0;
    end else if (busy) begin
      if (pos == 16 * TICK - 1) begin
        pos <= 0;
        bitCnt <= bitCnt + 1;
        rxd <= (bitCnt == 9) ? 1'b1 : frame[bitCnt + 1];
        busy <= (bitCnt != 9);
      end else begin
        pos <= pos + 1;
      end
    end
  end
endmodule : srx_partner

// ==== sim/srx_unit_monitor.sv ====
// Purpose: port-level checks on the serial receive unit
// Assumes: ce held high by the bench
// Notes: attached by bind at the foot of this file
`timescale 1ns/1ps
module srx_unit_monitor (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sckOut,
  input wire logic sckOe_n,
  input wire logic irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [5:0] awQ;
  logic [5:0] arQ;

  // ----------------------------------------
  // latched addresses and properties
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (s_axi_awvalid && s_axi_awready) awQ <= s_axi_awaddr;
    if (s_axi_arvalid && s_axi_arready) arQ <= s_axi_araddr;
  end

  property p_writeAnswer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_writeAnswer: assert property (p_writeAnswer) else $error("write response late");
  property p_writeHold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_writeHold: assert property (p_writeHold) else $error("write response dropped");
  property p_writeResp;
    $rose(s_axi_bvalid) |-> s_axi_bresp == (awQ[5] ? srx_pkg::RESP_SLVERR : srx_pkg::RESP_OKAY);
  endproperty
  a_writeResp: assert property (p_writeResp) else $error("write response code");
  property p_readAnswer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_readAnswer: assert property (p_readAnswer) else $error("read data late");
  property p_readHold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_readHold: assert property (p_readHold) else $error("read data dropped");
  property p_rxDataWidth;
    s_axi_rvalid && arQ[5:2] == srx_pkg::OFF_RXDATA[5:2] |-> s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_rxDataWidth: assert property (p_rxDataWidth) else $error("receive buffer wider than a byte");
  property p_unmappedRead;
    s_axi_rvalid && arQ[5] |-> s_axi_rdata == 32'h00000000 && s_axi_rresp == srx_pkg::RESP_SLVERR;
  endproperty
  a_unmappedRead: assert property (p_unmappedRead) else $error("unmapped read answered");
  property p_resetIdle;
    $fell(sys_rst) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && sckOe_n;
  endproperty
  a_resetIdle: assert property (p_resetIdle) else $error("outputs busy after reset");
  property p_clockIdle;
    sckOe_n |-> sckOut;
  endproperty
  a_clockIdle: assert property (p_clockIdle) else $error("clock pin low while released");
  property p_clockRate;
    $rose(sckOut) |=> !$rose(sckOut) [*8];
  endproperty
  a_clockRate: assert property (p_clockRate) else $error("clock pin faster than bit rate");
endmodule : srx_unit_monitor

bind srx_unit srx_unit_monitor u_srx_unit_monitor (.clock(clock), .sys_rst(sys_rst),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .sckOut(sckOut), .sckOe_n(sckOe_n), .irq(irq));

// ==== sim/tb.sv ====
// Purpose: self-checking bench for the serial receive unit
// Assumes: ce held high; one bit is 16*TICK clocks
// Notes: bytes drawn at random from a fixed seed
`timescale 1ns/1ps
module tb;
  localparam int TICK = 8;
  localparam logic [1:0] OK = srx_pkg::RESP_OKAY;
  logic clock, sys_rst, send, stopVal, rxd, sckIn, sckOut, sckOe_n, irq, busy;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [7:0] byteIn, b1, b2;
  int errCount, numChecks, seed, parity_error_flag;

  srx_unit u_srx_unit (.clock(clock), .sys_rst(sys_rst), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rxdPin(rxd), .sckIn(sckIn), .sckOut(sckOut), .sckOe_n(sckOe_n), .irq(irq));
  srx_partner #(.TICK(TICK)) u_partner (.clock(clock), .send(send), .byteIn(byteIn),
    .stopVal(stopVal), .rxd(rxd), .sck(sckIn), .busy(busy));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ----------------------------------------
  // compare and bus tasks
  // ----------------------------------------
  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chkWord

  task automatic chkResp(input logic [1:0] got, input logic [1:0] exp);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chkResp

  // answers are sampled at the falling edge, which still holds what the next rising edge sees
  task automatic regWr(input logic [5:0] a, input logic [31:0] v, output logic [1:0] rsp);
    logic aw, w, b;
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge clock);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      rsp = bresp;
      @(posedge clock);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : regWr

  task automatic wrOk(input logic [5:0] a, input logic [31:0] v);
    logic [1:0] rsp;
    regWr(a, v, rsp);
    chkResp(rsp, OK);
  endtask : wrOk

  task automatic expectRd(input logic [5:0] a, input logic [31:0] msk, input logic [31:0] exp,
                          input logic [1:0] er);
    logic ar, rv;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rv = 1'b0;
    while (!rv) begin
      @(negedge clock);
      ar = arvalid && arready;
      rv = rvalid;
      if (rv) chkWord(rdata & msk, exp);
      if (rv) chkResp(rresp, er);
      @(posedge clock);
      if (ar) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : expectRd

  task automatic startByte(input logic [7:0] b, input logic sv);
    @(posedge clock);
    send <= 1'b1;
    byteIn <= b;
    stopVal <= sv;
    @(posedge clock);
    send <= 1'b0;
  endtask : startByte

  task automatic waitByte(input int extra);
    @(negedge clock);
    while (busy) @(negedge clock);
    repeat (extra) @(posedge clock);
  endtask : waitByte

  task automatic sckPeriod(output int n);
    n = 0;
    @(negedge clock);
    while (sckOut) @(negedge clock);
    while (!sckOut) @(negedge clock);
    do begin @(negedge clock); n++; end while (sckOut);
    while (!sckOut) begin @(negedge clock); n++; end
  endtask : sckPeriod

  task automatic stopTest;
    if (errCount == 0 && numChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stopTest

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    #240000;
    errCount++;
    stopTest();
  end

  initial begin
    seed = $urandom(53);
    {sys_rst, stopVal} = 2'b11;
    {send, awvalid, wvalid, bready, arvalid, rready} = '0;
    {byteIn, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    errCount = 0;
    numChecks = 0;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    expectRd(srx_pkg::OFF_RXDATA, '1, 32'h0, OK);
    expectRd(srx_pkg::OFF_STATUS, '1, 32'h10, OK);
    wrOk(srx_pkg::OFF_RXDATA, 32'hA5);
    expectRd(srx_pkg::OFF_RXDATA, '1, 32'h0, OK);
    regWr(6'h20, 32'h1, r);
    chkResp(r, srx_pkg::RESP_SLVERR);
    expectRd(6'h24, '1, 32'h0, srx_pkg::RESP_SLVERR);
    wrOk(srx_pkg::OFF_BAUD, 32'(TICK - 1));
    wrOk(srx_pkg::OFF_MASK, 32'h1);
    wrOk(srx_pkg::OFF_CTRL, 32'h1);
    b1 = 8'($urandom);
    b2 = 8'($urandom);
    // second frame follows the first after only two idle clocks
    startByte(b1, 1'b1);
    waitByte(0);
    startByte(b2, 1'b1);
    chkWord({31'h0, irq}, 32'h1);
    expectRd(srx_pkg::OFF_RXDATA, '1, {24'h0, b1}, OK);
    wrOk(srx_pkg::OFF_STATUS, 32'h1);
    chkWord({31'h0, irq}, 32'h0);
    waitByte(40);
    expectRd(srx_pkg::OFF_RXDATA, '1, {24'h0, b2}, OK);
    expectRd(srx_pkg::OFF_STATUS, '1, 32'h11, OK);
    // unread byte pending: the next one overruns and is dropped
    startByte(8'($urandom), 1'b1);
    waitByte(40);
    wrOk(srx_pkg::OFF_MASK, 32'h0);
    chkWord({31'h0, irq}, 32'h0);
    wrOk(srx_pkg::OFF_CTRL, 32'h0);
    expectRd(srx_pkg::OFF_STATUS, '1, 32'h13, OK);
    expectRd(srx_pkg::OFF_RXDATA, '1, {24'h0, b2}, OK);
    wrOk(srx_pkg::OFF_STATUS, 32'hF);
    wrOk(srx_pkg::OFF_CTRL, 32'h1);
    startByte(8'($urandom), 1'b0);
    waitByte(40);
    expectRd(srx_pkg::OFF_STATUS, 32'h4, 32'h4, OK);
    for (int i = 0; i < 2; i++) begin
      wrOk(srx_pkg::OFF_STATUS, 32'hF);
      startByte(8'($urandom) | 8'h01, 1'b1);
      waitByte(40);
      wrOk(srx_pkg::OFF_POWER, 32'(1 << i));
      expectRd(srx_pkg::OFF_RXDATA, '1, 32'h0, OK);
      wrOk(srx_pkg::OFF_POWER, 32'h0);
    end
    wrOk(srx_pkg::OFF_CTRL, 32'h0);
    wrOk(srx_pkg::OFF_STATUS, 32'hF);
    wrOk(srx_pkg::OFF_CTRL, 32'h9);
    b1 = 8'($urandom);
    startByte(b1, 1'b1);
    waitByte(40);
    expectRd(srx_pkg::OFF_RXDATA, '1, {24'h0, b1}, OK);
    // sync internal clock, then async internal clock with output
    for (int i = 0; i < 2; i++) begin
      wrOk(srx_pkg::OFF_CTRL, 32'h0);
      wrOk(srx_pkg::OFF_MODE, 32'(1 - i));
      wrOk(srx_pkg::OFF_CTRL, 32'(1 + 4 * i));
      sckPeriod(parity_error_flag);
      chkWord(32'(parity_error_flag), 32'(16 * TICK));
      chkWord({31'h0, sckOe_n}, 32'h0);
    end
    wrOk(srx_pkg::OFF_CTRL, 32'h0);
    wrOk(srx_pkg::OFF_CTRL, 32'h2);
    b1 = 8'($urandom) | 8'h01;
    wrOk(srx_pkg::OFF_TXDATA, {24'h0, b1});
    expectRd(srx_pkg::OFF_STATUS, 32'hFF10, {16'h0, b1, 8'h10}, OK);
    wrOk(srx_pkg::OFF_CTRL, 32'h0);
    expectRd(srx_pkg::OFF_STATUS, 32'hFF10, 32'h10, OK);
    stopTest();
  end
endmodule : tb
